/* File: iec_encoder_counter.sv */
// Four-channel incremental encoder counter with index gating
`timescale 1ns/10ps
module iec_encoder_counter (
   input  logic                                 sys_clk,  // System clock
   input  logic                                 reset,    // Sync reset, high
   input  iec_pkg::iec_bus_req_s                bus_req,  // Register request
   input  logic [iec_pkg::NUM_TRK-1:0][iec_pkg::SW-1:0] track_mv, // Track mV
   input  logic [iec_pkg::SW-1:0]               index_mv, // Index input mV
   output logic [iec_pkg::DW-1:0]               rdata_r   // Read data
);
   import iec_pkg::*;

   iec_cmp_cfg_s         cmp_cfg [NUM_TRK];
   logic [NUM_DET-1:0]   lvl_r;
   logic [NUM_DET-1:0]   lvl_nxt;
   logic [NUM_DET-1:0]   sy1_r;
   logic [NUM_DET-1:0]   sy1_nxt;
   logic [NUM_DET-1:0]   sy2_r;
   logic [NUM_DET-1:0]   sy2_nxt;
   logic [NUM_DET-1:0]   prev_r;
   logic [NUM_DET-1:0]   prev_nxt;
   logic [NUM_DET-1:0]   rise;
   iec_ctrl_s            ctrl_r;
   iec_ctrl_s            ctrl_nxt;
   logic                 gate_r;
   logic                 gate_nxt;
   logic                 start_pulse;
   logic                 ctrl_wr;
   logic                 cnt_en;
   logic [DW-1:0]        count_r  [NUM_TRK];
   logic [DW-1:0]        count_nxt[NUM_TRK];
   logic [DW-1:0]        tick_r   [NUM_TRK];
   logic [DW-1:0]        tick_nxt [NUM_TRK];
   logic [DW-1:0]        period_r [NUM_TRK];
   logic [DW-1:0]        period_nxt[NUM_TRK];
   logic [DW-1:0]        rdata_nxt;

   // Detectors: four tracks plus the shared index
   genvar d;
   generate
      for (d = 0; d < NUM_DET; d++)
      begin : g_det
         logic signed [SW-1:0] samp;
         logic signed [SW-1:0] hi_mv;
         logic signed [SW-1:0] lo_mv;
         iec_cmp_cfg_s         cfg;
         if (d == IDX_DET)
         begin : g_idx
            assign samp = index_mv;
            // The index has no settings of its own
            assign cfg  = cmp_cfg[0];
         end
         else
         begin : g_trk
            // Fixed thresholds in this version, one set per track
            assign cmp_cfg[d] = '{ref_mv: REF_MV, hyst_mv: HYST_MV};
            assign samp = track_mv[d];
            assign cfg  = cmp_cfg[d];
         end
         assign hi_mv = cfg.ref_mv + (cfg.hyst_mv >>> 1);
         assign lo_mv = cfg.ref_mv - (cfg.hyst_mv >>> 1);

         always_comb
         begin
            if (lvl_r[d])
            begin
               lvl_nxt[d] = !(samp < lo_mv);
            end
            else
            begin
               lvl_nxt[d] = (samp > hi_mv);
            end
            sy1_nxt[d]  = lvl_r[d];
            sy2_nxt[d]  = sy1_r[d];
            prev_nxt[d] = sy2_r[d];
         end

         // Index flops start high so release from reset is no edge
         always_ff @(posedge sys_clk)
         begin
            if (reset)
            begin
               lvl_r[d]  <= DET_RST[d];
               sy1_r[d]  <= DET_RST[d];
               sy2_r[d]  <= DET_RST[d];
               prev_r[d] <= DET_RST[d];
            end
            else
            begin
               lvl_r[d]  <= lvl_nxt[d];
               sy1_r[d]  <= sy1_nxt[d];
               sy2_r[d]  <= sy2_nxt[d];
               prev_r[d] <= prev_nxt[d];
            end
         end

         assign rise[d] = sy2_r[d] & ~prev_r[d];
      end
   endgenerate

   // Control register and index gate
   assign ctrl_wr     = bus_req.wr && (bus_req.addr == CTRL_OFS);
   assign start_pulse = ctrl_wr && bus_req.wdata[CTRL_RUN] && !ctrl_r.run;
   // One gate shared by all channels
   assign cnt_en = ctrl_r.run && (ctrl_r.no_index || gate_r);

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr)
      begin
         ctrl_nxt.run      = bus_req.wdata[CTRL_RUN];
         ctrl_nxt.no_index = bus_req.wdata[CTRL_NOIDX];
         ctrl_nxt.dual     = bus_req.wdata[CTRL_DUAL +: 2];
      end
      if (start_pulse || !ctrl_r.run)
      begin
         // Unless no_index is set, every new measurement waits for a fresh index edge
         gate_nxt = 1'b0;
      end
      else
      begin
         gate_nxt = gate_r | rise[IDX_DET];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrl_r <= CTRL_RST;
         gate_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         gate_r <= gate_nxt;
      end
   end

   // Count channels
   genvar k;
   generate
      for (k = 0; k < NUM_TRK; k++)
      begin : g_ch
         logic odd_ch;
         logic paired_off;
         logic use_dir;
         assign odd_ch     = (k % 2) == 1;
         // Follower of a dual pair gives its track to the leader
         assign paired_off = odd_ch && ctrl_r.dual[k/2];
         assign use_dir    = !odd_ch && ctrl_r.dual[k/2];

         always_comb
         begin
            count_nxt[k]  = count_r[k];
            tick_nxt[k]   = tick_r[k];
            period_nxt[k] = period_r[k];
            if (start_pulse || !cnt_en || paired_off)
            begin
               count_nxt[k]  = '0;
               tick_nxt[k]   = '0;
               period_nxt[k] = '0;
            end
            else if (rise[k])
            begin
               // Only primary edges clock count and period
               period_nxt[k] = tick_r[k] + ONE_W;
               tick_nxt[k]   = '0;
               if (use_dir && sy2_r[k+1])
               begin
                  // Secondary high at primary rise: reverse turn
                  count_nxt[k] = count_r[k] - ONE_W;
               end
               else
               begin
                  count_nxt[k] = count_r[k] + ONE_W;
               end
            end
            else if (tick_r[k] != MAX_W)
            begin
               // Saturate at MAX_W; a rise after that makes period MAX_W + 1, which wraps to zero
               tick_nxt[k] = tick_r[k] + ONE_W;
            end
         end

         always_ff @(posedge sys_clk)
         begin
            if (reset)
            begin
               count_r[k]  <= '0;
               tick_r[k]   <= '0;
               period_r[k] <= '0;
            end
            else
            begin
               count_r[k]  <= count_nxt[k];
               tick_r[k]   <= tick_nxt[k];
               period_r[k] <= period_nxt[k];
            end
         end
      end
   endgenerate

   // Read mux, answer stands only in the cycle after the strobe
   always_comb
   begin
      rdata_nxt = '0;
      case (bus_req.addr)
         CTRL_OFS:
         begin
            rdata_nxt[CTRL_RUN]      = ctrl_r.run;
            rdata_nxt[CTRL_NOIDX]    = ctrl_r.no_index;
            rdata_nxt[CTRL_DUAL +: 2] = ctrl_r.dual;
         end
         STAT_OFS:
         begin
            rdata_nxt[STAT_RUN]  = ctrl_r.run;
            rdata_nxt[STAT_GATE] = cnt_en;
            rdata_nxt[STAT_LVL +: NUM_DET] = sy2_r;
         end
         COUNT_OFS:                  rdata_nxt = count_r[0];
         COUNT_OFS + WORD_STEP:      rdata_nxt = count_r[1];
         AW'(COUNT_OFS + 2*WORD_STEP):  rdata_nxt = count_r[2];
         AW'(COUNT_OFS + 3*WORD_STEP):  rdata_nxt = count_r[3];
         PERIOD_OFS:                    rdata_nxt = period_r[0];
         PERIOD_OFS + WORD_STEP:        rdata_nxt = period_r[1];
         AW'(PERIOD_OFS + 2*WORD_STEP): rdata_nxt = period_r[2];
         AW'(PERIOD_OFS + 3*WORD_STEP): rdata_nxt = period_r[3];
         default:                    rdata_nxt = '0;
      endcase
      if (!bus_req.rd)
      begin
         rdata_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

endmodule

/* File: iec_encoder_model.sv */
// Behavioural model of the encoder sensors ahead of the detectors
`timescale 1ns/10ps
module iec_encoder_model
   import iec_pkg::*;
(
   input  logic                       sys_clk,  // Clock
   input  logic [NUM_TRK-1:0]         trk,      // Commanded track levels
   input  logic                       idx,      // Commanded index level
   input  logic                       idx_open, // Index left unconnected
   output logic [NUM_TRK-1:0][SW-1:0] track_mv, // Track samples
   output logic [SW-1:0]              index_mv  // Index sample
);
   logic [NUM_TRK-1:0] prev_r = '0;
   always_ff @(posedge sys_clk)
      prev_r <= trk;
   // Edge overshoots one sample, then sits inside the band, so only a
   // hysteretic detector keeps the level
   always_comb
      for (int i = 0; i < NUM_TRK; i++)
         track_mv[i] = trk[i] ? (prev_r[i] ? 16'h0640 : 16'h07d0)
                              : (prev_r[i] ? 16'h03e8 : 16'h0578);
   // Open input floats high
   assign index_mv = (idx_open || idx) ? 16'h09c4 : 16'h01f4;
endmodule

/* File: iec_pkg.sv */
// Constants, register map and carrier types of the incremental encoder counter
// What this block does
// - Counters held reset until index, unless no-index
// - Index qualified with channel one comparator settings
// - Open index reads high, high is inactive
// - Dual-track direction from quadrature track phase
// - Timing and counting taken from primary track
// - Single-track types count without direction evaluation
// - Detector hysteresis: rise above upper, fall below lower
// - Reference 1.5 V, hysteresis 0.5 V, every track
// - Four single tracks or two quadrature pairs
// - Consumed follower channel reports constant zero
// - One index track gates all four channels
// - After start, wait for first index rising edge
// - Index gating re-armed at every measurement start
package iec_pkg;

   localparam int NUM_TRK = 4;
   localparam int NUM_DET = 5;
   localparam int IDX_DET = 4;
   localparam int AW      = 8;
   localparam int DW      = 32;
   localparam int SW      = 16;

   // Register byte offsets
   localparam logic [AW-1:0] CTRL_OFS   = 8'h00;
   localparam logic [AW-1:0] STAT_OFS   = 8'h04;
   localparam logic [AW-1:0] COUNT_OFS  = 8'h10;
   localparam logic [AW-1:0] PERIOD_OFS = 8'h20;
   localparam logic [AW-1:0] WORD_STEP  = 8'h04;

   // Control field positions
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_NOIDX = 1;
   localparam int CTRL_DUAL  = 2;

   // Status field positions
   localparam int STAT_RUN   = 0;
   localparam int STAT_GATE  = 1;
   localparam int STAT_LVL   = 4;

   // Detector thresholds in millivolts
   localparam logic signed [SW-1:0] REF_MV  = 16'sh05dc;
   localparam logic signed [SW-1:0] HYST_MV = 16'sh01f4;

   // Reset levels of the detectors: index idles high, tracks low
   localparam logic [NUM_DET-1:0] DET_RST = 5'h10;
   localparam logic [3:0]         CTRL_RST = 4'h0;
   localparam logic [DW-1:0]      ONE_W    = 32'h0000_0001;
   localparam logic [DW-1:0]      MAX_W    = 32'hffff_ffff;

   typedef struct packed {
      logic signed [SW-1:0] ref_mv;
      logic signed [SW-1:0] hyst_mv;
   } iec_cmp_cfg_s;

   typedef struct packed {
      logic [1:0] dual;
      logic       no_index;
      logic       run;
   } iec_ctrl_s;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } iec_bus_req_s;

endpackage

/* File: iec_properties.sv */
// Port checker for the encoder counter
`timescale 1ns/10ps
module iec_properties
   import iec_pkg::*;
(
   input  logic                           sys_clk,  // Clock
   input  logic                           reset,    // Sync reset
   input  iec_pkg::iec_bus_req_s          bus_req,  // Register request
   input  logic [NUM_TRK-1:0][SW-1:0]     track_mv, // Track samples
   input  logic [SW-1:0]                  index_mv, // Index sample
   input  logic [DW-1:0]                  rdata_r   // Read data
);
   logic [3:0] ctrl_r;
   logic [3:0] ctrl_nxt;
   logic       rs;
   logic       th;
   logic       tl;
   logic       il;
   logic       exp_lvl_r;
   logic [2:0] age_r;
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (bus_req.wr && bus_req.addr == CTRL_OFS)
         ctrl_nxt = bus_req.wdata[3:0];
   end
   always_ff @(posedge sys_clk)
      ctrl_r <= reset ? CTRL_RST : ctrl_nxt;
   assign rs = bus_req.rd && bus_req.addr == STAT_OFS;
   assign th = $signed(track_mv[1]) > REF_MV + (HYST_MV >>> 1);
   assign tl = $signed(track_mv[1]) < REF_MV - (HYST_MV >>> 1);
   assign il = $signed(index_mv) < REF_MV - (HYST_MV >>> 1);
   // Expected level of track two; age counts edges since it last moved,
   // since a crossing sample lasts one cycle and then sits inside the band
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         exp_lvl_r <= 1'b0;
         age_r     <= 3'h0;
      end
      else if (exp_lvl_r ? tl : th)
      begin
         exp_lvl_r <= !exp_lvl_r;
         age_r     <= 3'h0;
      end
      else if (age_r != 3'h7)
      begin
         age_r <= age_r + 3'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Clearing lands one edge after the control write, so it must be old
   property p_stop_cnt;
      bus_req.rd && bus_req.addr == COUNT_OFS && !ctrl_r[0]
         && !$past(ctrl_r[0]) |=> rdata_r == '0;
   endproperty
   a_stop_cnt: assert property (p_stop_cnt)
      else $error("count moved while stopped");
   property p_stop_gate;
      rs && !ctrl_r[0] |=> !rdata_r[STAT_GATE];
   endproperty
   a_stop_gate: assert property (p_stop_gate)
      else $error("gate open while stopped");
   property p_run_stat;
      rs |=> rdata_r[STAT_RUN] == $past(ctrl_r[0]);
   endproperty
   a_run_stat: assert property (p_run_stat)
      else $error("run status wrong");
   property p_fol2;
      bus_req.rd && bus_req.addr == 8'h14 && ctrl_r[2] && $past(ctrl_r[2])
         |=> rdata_r == '0;
   endproperty
   a_fol2: assert property (p_fol2)
      else $error("channel two not zero in pair");
   property p_fol4;
      bus_req.rd && bus_req.addr == 8'h1c && ctrl_r[3] && $past(ctrl_r[3])
         |=> rdata_r == '0;
   endproperty
   a_fol4: assert property (p_fol4)
      else $error("channel four not zero in pair");
   property p_trk_hi;
      rs && exp_lvl_r && age_r >= 3'h2 |=> rdata_r[STAT_LVL + 1];
   endproperty
   a_trk_hi: assert property (p_trk_hi)
      else $error("track level not high");
   property p_trk_lo;
      rs && !exp_lvl_r && age_r >= 3'h2 |=> !rdata_r[STAT_LVL + 1];
   endproperty
   a_trk_lo: assert property (p_trk_lo)
      else $error("track level not low");
   property p_idx_lo;
      il[*6] ##0 rs |=> !rdata_r[8];
   endproperty
   a_idx_lo: assert property (p_idx_lo)
      else $error("index level not low");
   c_gate: cover property (rs ##1 rdata_r[STAT_GATE]);
   c_count: cover property (bus_req.rd && bus_req.addr == COUNT_OFS
                            ##1 rdata_r != '0);
   c_dual: cover property (bus_req.wr && bus_req.wdata[3:2] == 2'h3);
endmodule

bind iec_encoder_counter iec_properties i_chk (
   .sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
   .track_mv(track_mv), .index_mv(index_mv), .rdata_r(rdata_r));

/* File: tb_top.sv */
// Self-checking bench for the encoder counter
`timescale 1ns/10ps
module tb_top;
   import iec_pkg::*;
   logic                       sys_clk;
   logic                       reset;
   logic                       idx;
   logic                       idx_open;
   logic [NUM_TRK-1:0]         trk;
   iec_bus_req_s               bus_req;
   logic [NUM_TRK-1:0][SW-1:0] track_mv;
   logic [SW-1:0]              index_mv;
   logic [DW-1:0]              rdata_r;
   int                         mismatches;
   int                         comparisons;
   `define CHK(g, e) check(g, e)
   iec_encoder_counter i_dut (.sys_clk(sys_clk), .reset(reset),
      .bus_req(bus_req), .track_mv(track_mv), .index_mv(index_mv),
      .rdata_r(rdata_r));
   iec_encoder_model i_enc (.sys_clk(sys_clk), .trk(trk), .idx(idx),
      .idx_open(idx_open), .track_mv(track_mv), .index_mv(index_mv));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task check(input logic [DW-1:0] g, input logic [DW-1:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task wrap_up;
      if (mismatches == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge sys_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge sys_clk);
      bus_req <= '{a, '0, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(rdata_r, e);
   endtask
   task cnt(input int ch, input logic [DW-1:0] e);
      rd(AW'(COUNT_OFS + 4 * ch), e);
   endtask
   // Rises are 12 cycles apart when called back to back
   task step(input int i);
      @(posedge sys_clk);
      trk[i] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      trk[i] <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask
   task restart(input logic [DW-1:0] d);
      wr(CTRL_OFS, '0);
      wr(CTRL_OFS, d);
   endtask
   task t_idle;
      rd(STAT_OFS, 32'h0000_0100);
      idx_open <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(STAT_OFS, 32'h0000_0000);
      wr(8'h40, 32'h0000_000f);
      rd(8'h40, '0);
      rd(CTRL_OFS, '0);
      step(0);
      cnt(0, '0);
   endtask
   task t_gate;
      wr(CTRL_OFS, 32'h0000_0001);
      step(0);
      step(2);
      cnt(0, '0);
      rd(STAT_OFS, 32'h0000_0001);
      @(posedge sys_clk);
      idx <= 1'b1;
      repeat (6) @(posedge sys_clk);
      idx <= 1'b0;
      repeat (6) @(posedge sys_clk);
      step(0);
      step(2);
      cnt(0, 32'h0000_0001);
      cnt(2, 32'h0000_0001);
      rd(STAT_OFS, 32'h0000_0003);
      restart(32'h0000_0001);
      step(0);
      cnt(0, '0);
      rd(STAT_OFS, 32'h0000_0001);
   endtask
   task t_single;
      restart(32'h0000_0003);
      for (int i = 0; i < NUM_TRK; i++)
         repeat (i + 2) step(i);
      for (int i = 0; i < NUM_TRK; i++)
         cnt(i, DW'(i + 2));
      rd(PERIOD_OFS, 32'h0000_000c);
   endtask
   task t_dual;
      restart(32'h0000_000f);
      repeat (3) step(0);
      repeat (2) step(2);
      @(posedge sys_clk);
      trk[1] <= 1'b1;
      repeat (5) step(0);
      rd(STAT_OFS, 32'h0000_0023);
      rd(CTRL_OFS, 32'h0000_000f);
      cnt(0, 32'hffff_fffe);
      cnt(2, 32'h0000_0002);
      trk[1] <= 1'b0;
      repeat (2) step(1);
      cnt(0, 32'hffff_fffe);
      cnt(1, '0);
      cnt(3, '0);
   endtask
   initial
   begin
      reset = 1'b1;
      idx = 1'b0;
      idx_open = 1'b1;
      trk = '0;
      bus_req = '0;
      mismatches = 0;
      comparisons = 0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      t_idle();
      t_gate();
      t_single();
      t_dual();
      wrap_up();
   end
endmodule
